/* hw/ioxp_defs.vh */
// constants of the two-wire port expander register block
`ifndef IOXP_DEFS_VH
`define IOXP_DEFS_VH
`define IOXP_REG_IN0      8'h00
`define IOXP_REG_IN1      8'h01
`define IOXP_REG_OUT0     8'h02
`define IOXP_REG_OUT1     8'h03
`define IOXP_REG_INV0     8'h04
`define IOXP_REG_INV1     8'h05
`define IOXP_REG_DIR0     8'h06
`define IOXP_REG_DIR1     8'h07
`define IOXP_REG_PUP0     8'h08
`define IOXP_REG_PUP1     8'h09
`define IOXP_RST_OUT      8'hFF
`define IOXP_RST_INV      8'h00
`define IOXP_RST_DIR      8'hFF
`define IOXP_RST_PUP      8'hFF
`define IOXP_ADDR_FIXED   4'h4
`define IOXP_RW_BIT       0
`endif

/* hw/ioxp_regs.v */
// two-wire slave, register pairs and pin control of a 16-bit port expander
//
// Functional notes
// - three strap pins set low address bits
// - address byte last bit: one reads
// - first write byte loads the pointer
// - codes 00h..09h select five register pairs
// - pointer is write only, never read
// - input registers show pin level, any direction
// - writes to input registers are ignored
// - input registers follow pins, no reset value; the code resets their synchroniser flops to zero
// - output bits drive only output pins
// - output register reads return stored value
// - invert bit one flips input level
// - direction one makes pin high impedance
// - direction zero drives output register level
// - pull-up bit zero disconnects pull-up
// - pull-up bits reset to one
// - bit n maps to pin n
// - pointer toggles within pair per byte
`timescale 1ns/1ps
`include "ioxp_defs.vh"

module ioxp_regs #(
	parameter [3:0] ADDR_FIXED = `IOXP_ADDR_FIXED
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        sys_rst,
	// address straps
	input  wire        addr_strap_bit0,
	input  wire        addr_strap_bit1,
	input  wire        addr_strap_bit2,
	// two-wire bus, open drain data
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_oe_q,
	// port pins
	input  wire [7:0]  port0_pin_in,
	input  wire [7:0]  port1_pin_in,
	output reg  [7:0]  port0_pin_out_q,
	output reg  [7:0]  port1_pin_out_q,
	output reg  [7:0]  port0_pin_oe_q,
	output reg  [7:0]  port1_pin_oe_q,
	output reg  [7:0]  port0_pullup_q,
	output reg  [7:0]  port1_pullup_q
);

	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_ADDR = 3'd1;
	localparam [2:0] ST_ACK  = 3'd2;
	localparam [2:0] ST_WR   = 3'd3;
	localparam [2:0] ST_RD   = 3'd4;
	localparam [2:0] ST_RACK = 3'd5;
	localparam [2:0] ST_RLD  = 3'd6;

	// reset images, split per bit inside the pin slices
	localparam [7:0] RST_OUT = `IOXP_RST_OUT;
	localparam [7:0] RST_DIR = `IOXP_RST_DIR;
	localparam [7:0] RST_PUP = `IOXP_RST_PUP;

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	reg [1:0]  scl_s_q;
	reg [1:0]  sda_s_q;
	reg [15:0] pin_m_q;
	reg [15:0] pin_s_q;
	reg [2:0]  strap_m_q;
	reg [2:0]  strap_s_q;
	reg        scl_d1_q;
	reg        sda_d1_q;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_s_q   <= 2'h3;
			sda_s_q   <= 2'h3;
			scl_d1_q  <= 1'b1;
			sda_d1_q  <= 1'b1;
			strap_m_q <= 3'h0;
			strap_s_q <= 3'h0;
		end else begin
			scl_s_q   <= {scl_s_q[0], scl_in};
			sda_s_q   <= {sda_s_q[0], sda_in};
			scl_d1_q  <= scl_s_q[1];
			sda_d1_q  <= sda_s_q[1];
			strap_m_q <= {addr_strap_bit2, addr_strap_bit1,
				addr_strap_bit0};
			strap_s_q <= strap_m_q;
		end
	end

	wire scl_c   = scl_s_q[1];
	wire sda_c   = sda_s_q[1];
	wire scl_r   = scl_c & ~scl_d1_q;
	wire scl_f   = ~scl_c & scl_d1_q;
	wire start_c = scl_c & scl_d1_q & sda_d1_q & ~sda_c;
	wire stop_c  = scl_c & scl_d1_q & ~sda_d1_q & sda_c;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [7:0] out0_q, out1_q, inv0_q, inv1_q;
	reg [7:0] dir0_q, dir1_q, pup0_q, pup1_q;
	reg [7:0] ptr_q;
	reg [2:0] state_q;
	reg [2:0] bit_q;
	reg [7:0] shift_q;
	reg       rw_q;
	reg       cmd_next_q;
	reg       match_q;
	reg       wr_strobe;
	reg [7:0] rd_data;

	// inputs follow pins through inversion; the two synchroniser flops per pin reset to zero
	wire [7:0] in0;
	wire [7:0] in1;

	always @* begin
		case (ptr_q)
		`IOXP_REG_IN0:  rd_data = in0;
		`IOXP_REG_IN1:  rd_data = in1;
		`IOXP_REG_OUT0: rd_data = out0_q;
		`IOXP_REG_OUT1: rd_data = out1_q;
		`IOXP_REG_INV0: rd_data = inv0_q;
		`IOXP_REG_INV1: rd_data = inv1_q;
		`IOXP_REG_DIR0: rd_data = dir0_q;
		`IOXP_REG_DIR1: rd_data = dir1_q;
		`IOXP_REG_PUP0: rd_data = pup0_q;
		`IOXP_REG_PUP1: rd_data = pup1_q;
		default:        rd_data = 8'h00;
		endcase
	end

	wire       ptr_ok  = (ptr_q <= `IOXP_REG_PUP1);
	wire [7:0] ptr_alt = {ptr_q[7:1], ~ptr_q[0]};
	wire [6:0] my_addr = {ADDR_FIXED, strap_s_q};

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	// input and undefined codes get no enable, so a byte sent there
	// leaves every register alone; only the pointer still toggles
	wire wr_ok   = wr_strobe & ptr_ok;
	wire wr_out0 = wr_ok & (ptr_q == `IOXP_REG_OUT0);
	wire wr_out1 = wr_ok & (ptr_q == `IOXP_REG_OUT1);
	wire wr_inv0 = wr_ok & (ptr_q == `IOXP_REG_INV0);
	wire wr_inv1 = wr_ok & (ptr_q == `IOXP_REG_INV1);
	wire wr_dir0 = wr_ok & (ptr_q == `IOXP_REG_DIR0);
	wire wr_dir1 = wr_ok & (ptr_q == `IOXP_REG_DIR1);
	wire wr_pup0 = wr_ok & (ptr_q == `IOXP_REG_PUP0);
	wire wr_pup1 = wr_ok & (ptr_q == `IOXP_REG_PUP1);

	// output pair
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out0_q <= `IOXP_RST_OUT;
			out1_q <= `IOXP_RST_OUT;
		end else begin
			if (wr_out0)
				out0_q <= shift_q;
			if (wr_out1)
				out1_q <= shift_q;
		end
	end

	// inversion pair
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			inv0_q <= `IOXP_RST_INV;
			inv1_q <= `IOXP_RST_INV;
		end else begin
			if (wr_inv0)
				inv0_q <= shift_q;
			if (wr_inv1)
				inv1_q <= shift_q;
		end
	end

	// direction pair
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dir0_q <= `IOXP_RST_DIR;
			dir1_q <= `IOXP_RST_DIR;
		end else begin
			if (wr_dir0)
				dir0_q <= shift_q;
			if (wr_dir1)
				dir1_q <= shift_q;
		end
	end

	// pull-up pair
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pup0_q <= `IOXP_RST_PUP;
			pup1_q <= `IOXP_RST_PUP;
		end else begin
			if (wr_pup0)
				pup0_q <= shift_q;
			if (wr_pup1)
				pup1_q <= shift_q;
		end
	end

	// ----------------------------------------------------------------
	// bus state machine
	// ----------------------------------------------------------------
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q    <= ST_IDLE;
			bit_q      <= 3'h0;
			shift_q    <= 8'h00;
			rw_q       <= 1'b0;
			cmd_next_q <= 1'b0;
			match_q    <= 1'b0;
			ptr_q      <= 8'h00;
			sda_oe_q   <= 1'b0;
			wr_strobe  <= 1'b0;
		end else begin
			wr_strobe <= 1'b0;
			if (wr_strobe)
				ptr_q <= ptr_alt;
			if (start_c) begin
				state_q  <= ST_ADDR;
				bit_q    <= 3'h0;
				sda_oe_q <= 1'b0;
			end else if (stop_c) begin
				state_q  <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (state_q)
				ST_IDLE: ;
				ST_ADDR: if (scl_r) begin
					shift_q <= {shift_q[6:0], sda_c};
					bit_q   <= bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						rw_q       <= sda_c;
						match_q    <= (shift_q[6:0] == my_addr);
						cmd_next_q <= ~sda_c;
						state_q    <= ST_ACK;
					end
				end
				ST_ACK: if (scl_f) begin
					if (!sda_oe_q) begin
						// drive ack on the low phase
						if (match_q) sda_oe_q <= 1'b1;
						else state_q <= ST_IDLE;
					end else begin
						sda_oe_q <= 1'b0;
						bit_q    <= 3'h0;
						if (rw_q) begin
							// snapshot holds for the byte
							shift_q  <= rd_data;
							sda_oe_q <= ~rd_data[7];
							state_q  <= ST_RD;
						end else
							state_q <= ST_WR;
					end
				end
				ST_WR: if (scl_r) begin
					shift_q <= {shift_q[6:0], sda_c};
					bit_q   <= bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						if (cmd_next_q)
							ptr_q <= {shift_q[6:0], sda_c};
						else
							wr_strobe <= 1'b1;
						cmd_next_q <= 1'b0;
						state_q    <= ST_ACK;
					end
				end
				ST_RD: if (scl_f) begin
					bit_q <= bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						sda_oe_q <= 1'b0;
						ptr_q    <= ptr_alt;
						state_q  <= ST_RACK;
					end else begin
						shift_q  <= {shift_q[6:0], 1'b0};
						sda_oe_q <= ~shift_q[6];
					end
				end
				ST_RACK: if (scl_r) begin
					// master nack ends the read; ack fetches the partner
					if (sda_c)
						state_q <= ST_IDLE;
					else begin
						shift_q <= rd_data;
						state_q <= ST_RLD;
					end
				end
				ST_RLD: if (scl_f) begin
					// top bit of the next byte goes out on the low phase
					sda_oe_q <= ~shift_q[7];
					bit_q    <= 3'h0;
					state_q  <= ST_RD;
				end
				default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// pin slices
	// ----------------------------------------------------------------
	// bit n of every port register meets pin n of its port; one slice
	// per bit keeps that mapping in a single place
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
			// two flops per pin; the first is read only by the second
			always @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					pin_m_q[gi]     <= 1'b0;
					pin_m_q[gi + 8] <= 1'b0;
					pin_s_q[gi]     <= 1'b0;
					pin_s_q[gi + 8] <= 1'b0;
				end else begin
					pin_m_q[gi]     <= port0_pin_in[gi];
					pin_m_q[gi + 8] <= port1_pin_in[gi];
					pin_s_q[gi]     <= pin_m_q[gi];
					pin_s_q[gi + 8] <= pin_m_q[gi + 8];
				end
			end

			// live level, inverted on request whatever the direction
			assign in0[gi] = pin_s_q[gi] ^ inv0_q[gi];
			assign in1[gi] = pin_s_q[gi + 8] ^ inv1_q[gi];

			// drivers follow the registers one clock later
			always @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					port0_pin_out_q[gi] <= RST_OUT[gi];
					port1_pin_out_q[gi] <= RST_OUT[gi];
					port0_pin_oe_q[gi]  <= ~RST_DIR[gi];
					port1_pin_oe_q[gi]  <= ~RST_DIR[gi];
					port0_pullup_q[gi]  <= RST_PUP[gi];
					port1_pullup_q[gi]  <= RST_PUP[gi];
				end else begin
					port0_pin_out_q[gi] <= out0_q[gi];
					port1_pin_out_q[gi] <= out1_q[gi];
					port0_pin_oe_q[gi]  <= ~dir0_q[gi];
					port1_pin_oe_q[gi]  <= ~dir1_q[gi];
					port0_pullup_q[gi]  <= pup0_q[gi];
					port1_pullup_q[gi]  <= pup1_q[gi];
				end
			end
		end
	endgenerate

endmodule

/* test/ioxp_asserts.sv */
// assertions on the port expander register block
`timescale 1ns/1ps
module ioxp_asserts(
	input wire logic       sys_clk, sys_rst, scl_in, sda_oe_q,
	input wire logic [7:0] port0_pin_out_q, port1_pin_oe_q,
	input wire logic [7:0] port0_pin_oe_q, port1_pullup_q,
	input wire logic [7:0] port0_pullup_q);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	rst_hold_a: assert property (disable iff (1'b0) sys_rst |->
		!sda_oe_q && port0_pin_oe_q == 8'h00 && port1_pullup_q == 8'hFF)
		else $error("bad reset state");
	rst_exit_a: assert property ($past(sys_rst) |->
		port1_pin_oe_q == 8'h00 && port0_pin_out_q == 8'hFF)
		else $error("bad state after reset");
	ack_hold_a: assert property ($rose(sda_oe_q) |->
		sda_oe_q [*6]) else $error("data pull too short");
	sda_edge_a: assert property ($changed(sda_oe_q) |-> !scl_in)
		else $error("data moved with clock high");
	out_rise_a: assert property ($changed(port0_pin_out_q) |-> scl_in)
		else $error("output moved off a bit");
	dir_rise_a: assert property ($changed(port1_pin_oe_q) |-> scl_in)
		else $error("direction moved off a bit");
	dir_split_a: assert property ($changed(port0_pin_oe_q) |->
		$stable(port1_pin_oe_q)) else $error("both ports moved");
	pup_split_a: assert property ($changed(port0_pullup_q) |->
		$stable(port1_pullup_q) && $stable(port0_pin_oe_q))
		else $error("pull-up write leaked");
	cover property ($rose(sda_oe_q));
	cover property ($changed(port0_pin_out_q));
	cover property ($changed(port0_pullup_q));
endmodule

bind ioxp_regs ioxp_asserts i_chk(.*);

/* test/ioxp_master.sv */
// two-wire bus master facing the expander
`timescale 1ns/1ps
module ioxp_master(
	input wire logic  sys_clk, sda_oe_q,
	output logic      scl = 1'b1,
	output wire logic sda);
	logic lo = 1'b0;
	// open drain with pull-up: released line reads high
	assign sda = !(lo || sda_oe_q);
	task hp;
		repeat (12) @(negedge sys_clk);
	endtask
	// data moves only well after the clock fell, never with it
	task bt(input logic b, output logic r);
		lo = !b; hp; scl = 1'b1; hp; r = sda; scl = 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask
	task st;
		lo = 1'b0; hp; scl = 1'b1; hp; lo = 1'b1; hp; scl = 1'b0; hp;
	endtask
	task sp;
		lo = 1'b1; hp; scl = 1'b1; hp; lo = 1'b0; hp;
	endtask
	task by(input logic [7:0] d, input logic m, output logic [7:0] q,
		output logic k);
		for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
		bt(m, k);
	endtask
	task wr(input logic [6:0] a, input logic [7:0] p, d0, d1,
		output logic ok);
		logic [7:0] q;
		logic k0, k1, k2, k3;
		st; by({a, 1'b0}, 1, q, k0); by(p, 1, q, k1);
		by(d0, 1, q, k2); by(d1, 1, q, k3); sp;
		ok = !(k0 | k1 | k2 | k3);
	endtask
	task rd(input logic [6:0] a, input logic [7:0] p,
		output logic [7:0] q0, q1, output logic ok);
		logic [7:0] q;
		logic k0, k1, k2, k3;
		st; by({a, 1'b0}, 1, q, k0); by(p, 1, q, k1);
		st; by({a, 1'b1}, 1, q, k2); by(8'hFF, 0, q0, k3);
		by(8'hFF, 1, q1, k3); sp;
		ok = !(k0 | k1 | k2);
	endtask
endmodule

/* test/testbench.sv */
// self-checking bench of the port expander register block
`timescale 1ns/1ps
module testbench;
	localparam logic [6:0] ADR = 7'h25;
	localparam logic [7:0] PIN0 = 8'h3C, PIN1 = 8'hC3;
	logic sys_clk = 1'b0, sys_rst = 1'b0, ok;
	logic [7:0] q0, q1;
	wire logic [7:0] o0, o1, e0, e1, u0, u1;
	wire scl, sda, sda_oe_q;
	int fail_count = 0, compares = 0;
	initial forever #25 sys_clk = !sys_clk;
	// straps 101 with fixed upper nibble give address 25h
	ioxp_regs i_dut(.sys_clk, .sys_rst, .addr_strap_bit0(1'b1),
		.addr_strap_bit1(1'b0), .addr_strap_bit2(1'b1), .scl_in(scl),
		.sda_in(sda), .sda_oe_q, .port0_pin_in((e0 & o0) | (~e0 & PIN0)),
		.port1_pin_in((e1 & o1) | (~e1 & PIN1)), .port0_pin_out_q(o0),
		.port1_pin_out_q(o1), .port0_pin_oe_q(e0), .port1_pin_oe_q(e1),
		.port0_pullup_q(u0), .port1_pullup_q(u1));
	ioxp_master i_mst(.sys_clk, .sda_oe_q, .scl, .sda);
	task ck(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task w(input logic [7:0] p, d0, d1);
		i_mst.wr(ADR, p, d0, d1, ok);
		ck("write ack", 8'h01, {7'h0, ok});
	endtask
	task r(input logic [7:0] p, x0, x1);
		i_mst.rd(ADR, p, q0, q1, ok);
		ck("read ack", 8'h01, {7'h0, ok});
		ck("first byte", x0, q0);
		ck("second byte", x1, q1);
	endtask
	task t_defaults;
		ck("pull-up 1", 8'hFF, u1);
		r(8'h02, 8'hFF, 8'hFF);
		r(8'h05, 8'h00, 8'h00);
		r(8'h07, 8'hFF, 8'hFF);
		r(8'h08, 8'hFF, 8'hFF);
		r(8'h00, PIN0, PIN1);
	endtask
	task t_drive;
		w(8'h03, 8'hA5, 8'h5A);
		w(8'h06, 8'h00, 8'hF0);
		ck("enable 0", 8'hFF, e0);
		ck("enable 1", 8'h0F, e1);
		ck("drive 0", 8'h5A, o0);
		ck("drive 1", 8'hA5, o1);
		r(8'h01, 8'hC5, 8'h5A);
		r(8'h03, 8'hA5, 8'h5A);
	endtask
	task t_invert;
		w(8'h04, 8'hFF, 8'h0F);
		r(8'h00, 8'hA5, 8'hCA);
		r(8'h05, 8'h0F, 8'hFF);
	endtask
	task t_pullup;
		w(8'h09, 8'h00, 8'hF0);
		ck("pull-up 0", 8'hF0, u0);
		ck("pull-up 1", 8'h00, u1);
	endtask
	task t_refuse;
		w(8'h00, 8'h11, 8'h22);
		w(8'h0A, 8'h33, 8'h44);
		r(8'h0A, 8'h00, 8'h00);
		r(8'h00, 8'hA5, 8'hCA);
		r(8'h02, 8'h5A, 8'hA5);
		i_mst.wr(7'h24, 8'h02, 8'h00, 8'h00, ok);
		ck("foreign ack", 8'h00, {7'h0, ok});
		ck("drive 0", 8'h5A, o0);
	endtask
	task finish_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a run needs about 25k clocks; give it a wide margin
	initial begin
		#3000000;
		fail_count++;
		finish_test;
	end
	initial begin
		// a real edge on reset, so no flop sits unknown at the first clock
		#1 sys_rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		t_defaults;
		t_drive;
		t_invert;
		t_pullup;
		t_refuse;
		finish_test;
	end
endmodule
